// *** src/conv_ctrl_regs.svh ***
// constants for the converter start-of-conversion control block
// assumes an 8-bit special-register port with 8-bit addresses
// Overview of operation
// - throughput up to 200 ksps sustained
// - conversion clock is sysclk over divider plus one
// - two-bit field picks one of four starts
// - software start: writing busy bit one starts
// - timer three overflow starts a conversion
// - rising edge on external start pin starts
// - timer two overflow starts a conversion
// - busy bit high during conversion, low after
// - busy falling edge at end of conversion sets done flag, interrupt
// - result bytes valid while done flag set
// - timers use low or high overflow by mode
// - converter works only while enable bit set
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
`define ADDR_CONFIG 8'hBC
`define ADDR_CONTROL 8'hBA
`define ADDR_RESULT_HIGH 8'hBF
`define ADDR_RESULT_LOW 8'hBE
`define ADDR_IE_GROUP2 8'hE7
`define ADDR_IP_GROUP2 8'hF7
`define CFG_DIV_LSB 3
`define CFG_DIV_MSB 7
`define CFG_RESET 8'hF8
`define CTL_ENABLE_BIT 7
`define CTL_DONE_BIT 5
`define CTL_BUSY_BIT 4
`define CTL_SRC_LSB 2
`define CTL_SRC_MSB 3
`define CTL_RESET 8'h00
`define IE2_EOC_BIT 4
`define IE2_WIN_BIT 3
`define IP2_EOC_BIT 4
`define GROUP2_RESET 8'h00
`define CONV_CLOCKS 12
`define MAX_RATE_KSPS 200
`define SYSCLK_MHZ 250
`define MIN_SAMPLE_CYCLES ((`SYSCLK_MHZ * 1000 + `MAX_RATE_KSPS - 1) / `MAX_RATE_KSPS)
`endif

// *** src/conv_ctrl_pkg.sv ***
// types for the converter start-of-conversion control block
// assumes the constants header is compiled alongside
package conv_ctrl_pkg;
  typedef enum logic [1:0] {
    SRC_SOFTWARE,
    SRC_TIMER3,
    SRC_EXTERNAL,
    SRC_TIMER2
  } start_src_e;
  typedef enum logic {
    ST_IDLE,
    ST_CONVERT
  } conv_state_e;
endpackage

// *** src/start_pin_filter.sv ***
// synchroniser and rising-edge detector for the external start pin
// assumes pin is asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module start_pin_filter (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // pin and event
  input wire logic pin_i,
  output logic rise_o
);
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;
  // three stages; first stage only feeds the second
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // level changes only when stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b0;
    end else if (sync2_q == sync3_q) begin
      level_q <= sync3_q;
    end
  end
  assign rise_o = (sync2_q == sync3_q) && sync3_q && !level_q;
endmodule // start_pin_filter
`default_nettype wire

// *** src/conv_start_ctrl.sv ***
// start-of-conversion control for a 10-bit successive-approximation converter
// assumes a single-cycle 8-bit register port from the cpu core and an
// analog core that returns a 10-bit result after the last conversion clock
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_regs.svh"
module conv_start_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_CLOCKS = `CONV_CLOCKS,
  parameter int MIN_SAMPLE_CYCLES = `MIN_SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // timer overflow pulses and split-mode selects
  input wire logic timer2_low_ovf_i,
  input wire logic timer2_high_ovf_i,
  input wire logic timer2_split_i,
  input wire logic timer3_low_ovf_i,
  input wire logic timer3_high_ovf_i,
  input wire logic timer3_split_i,
  // external start pin
  input wire logic external_convert_start_i,
  // analog core
  input wire logic [9:0] sar_result_i,
  output logic conv_clk_en_o,
  output logic sample_o,
  output logic converter_enable_o,
  // interrupt request
  output logic eoc_irq_o,
  output logic eoc_priority_o
);
  logic [7:0] config_q;
  logic [7:0] control_q;
  logic [7:0] ie2_q;
  logic [7:0] ip2_q;
  logic [9:0] result_q;
  logic [4:0] div_cnt_q;
  logic [4:0] clk_cnt_q;
  logic [15:0] spacing_q;
  conv_state_e state_q;
  logic conv_tick;
  logic ext_rise;
  logic start_evt;
  logic finish;
  logic sw_start;
  logic wr_ctl;
  logic t2_ovf;
  logic t3_ovf;
  start_src_e src;

  start_pin_filter u_pin (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(external_convert_start_i),
    .rise_o(ext_rise)
  );

  assign wr_ctl = reg_wr_i && (reg_addr_i == `ADDR_CONTROL);
  assign sw_start = wr_ctl && reg_wdata_i[`CTL_BUSY_BIT];
  assign src = start_src_e'(control_q[`CTL_SRC_MSB:`CTL_SRC_LSB]);

  // 8-bit timers overflow from the low byte, 16-bit ones from the high byte
  assign t2_ovf = timer2_split_i ? timer2_low_ovf_i : timer2_high_ovf_i;
  assign t3_ovf = timer3_split_i ? timer3_low_ovf_i : timer3_high_ovf_i;

  // select trigger; a source that is not selected is simply ignored
  always_comb begin
    start_evt = 1'b0;
    unique case (src)
      SRC_SOFTWARE: start_evt = sw_start;
      SRC_TIMER3: start_evt = t3_ovf;
      SRC_EXTERNAL: start_evt = ext_rise;
      SRC_TIMER2: start_evt = t2_ovf;
    endcase
  end

  // conversion clock divider, held in reset outside a conversion
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= 5'h00;
    end else if (state_q != ST_CONVERT || conv_tick) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 5'h01;
    end
  end
  // one tick every divider plus one system clocks; clearing enable stops it at once
  assign conv_tick = (state_q == ST_CONVERT) &&
                     control_q[`CTL_ENABLE_BIT] &&
                     (div_cnt_q == config_q[`CFG_DIV_MSB:`CFG_DIV_LSB]);
  assign conv_clk_en_o = conv_tick;
  assign finish = conv_tick && (clk_cnt_q == 5'(CONV_CLOCKS - 1));

  // conversion sequencer; new starts ignored while converting
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      clk_cnt_q <= 5'h00;
    end else if (!control_q[`CTL_ENABLE_BIT]) begin
      state_q <= ST_IDLE;
      clk_cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          clk_cnt_q <= 5'h00;
          // spacing guard keeps the sample rate within its ceiling
          if (start_evt && spacing_q == 16'h0000) begin
            state_q <= ST_CONVERT;
          end
        end
        // events during a conversion are dropped, never queued
        ST_CONVERT: begin
          if (finish) begin
            state_q <= ST_IDLE;
          end else if (conv_tick) begin
            clk_cnt_q <= clk_cnt_q + 5'h01;
          end
        end
      endcase
    end
  end
  // tracking runs whenever the converter is on and idle
  assign sample_o = (state_q == ST_IDLE) && control_q[`CTL_ENABLE_BIT];

  // least spacing between starts for the rated throughput
  // limitation: the count is fixed in system clocks, so another clock needs a new count
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spacing_q <= 16'h0000;
    end else if (state_q == ST_IDLE && start_evt && spacing_q == 16'h0000 &&
                 control_q[`CTL_ENABLE_BIT]) begin
      spacing_q <= 16'(MIN_SAMPLE_CYCLES - 1);
    end else if (spacing_q != 16'h0000) begin
      spacing_q <= spacing_q - 16'h0001;
    end
  end

  // control register: busy mirrors the sequencer, done is sticky
  // busy rises one cycle after the sequencer enters conversion and drops at the same edge as done sets
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_q <= `CTL_RESET;
    end else begin
      if (wr_ctl) begin
        control_q[7:6] <= reg_wdata_i[7:6];
        control_q[3:0] <= reg_wdata_i[3:0];
        control_q[`CTL_DONE_BIT] <= reg_wdata_i[`CTL_DONE_BIT] &
                                    control_q[`CTL_DONE_BIT];
      end
      // completion wins over a same-cycle clear
      if (finish) begin
        control_q[`CTL_DONE_BIT] <= 1'b1;
      end
      control_q[`CTL_BUSY_BIT] <= (state_q == ST_CONVERT) && !finish;
    end
  end

  // result captured with done so data is valid whenever done reads one
  // a disable in mid-conversion leaves the previous result in place
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q <= 10'h000;
    end else if (finish) begin
      result_q <= sar_result_i;
    end
  end

  // divider configuration register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      config_q <= `CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `ADDR_CONFIG) begin
      config_q <= reg_wdata_i;
    end
  end

  // extended interrupt enable and priority registers
  // only the converter bits leave the block; the rest is storage for software
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ie2_q <= `GROUP2_RESET;
      ip2_q <= `GROUP2_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_IE_GROUP2) begin
        ie2_q <= reg_wdata_i;
      end
      if (reg_addr_i == `ADDR_IP_GROUP2) begin
        ip2_q <= reg_wdata_i;
      end
    end
  end

  // request follows the sticky flag so it stays until software clears it
  assign eoc_irq_o = control_q[`CTL_DONE_BIT] && ie2_q[`IE2_EOC_BIT];
  assign eoc_priority_o = ip2_q[`IP2_EOC_BIT];
  assign converter_enable_o = control_q[`CTL_ENABLE_BIT];

  // read mux; unmapped addresses read zero
  // result bytes are not latched as a pair, so read both between conversions
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADDR_CONFIG: reg_rdata_o <= config_q;
        `ADDR_CONTROL: reg_rdata_o <= control_q;
        `ADDR_RESULT_HIGH: reg_rdata_o <= {6'h00, result_q[9:8]};
        `ADDR_RESULT_LOW: reg_rdata_o <= result_q[7:0];
        `ADDR_IE_GROUP2: reg_rdata_o <= ie2_q;
        `ADDR_IP_GROUP2: reg_rdata_o <= ip2_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // conv_start_ctrl
`default_nettype wire

// *** test/conv_start_checker.sv ***
// checker for the converter start control block
// assumes it is bound onto conv_start_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module conv_start_checker (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // converter side
  input wire logic conv_clk_en_o,
  input wire logic sample_o,
  input wire logic converter_enable_o,
  input wire logic eoc_irq_o,
  input wire logic eoc_priority_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // control register write strobe
  wire logic ctl_wr = reg_wr_i && reg_addr_i == 8'hBA;
  logic [1:0] src_seen_q;
  // source field as last written, so a busy write is judged only in software mode
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_seen_q <= 2'b00;
    end else if (ctl_wr) begin
      src_seen_q <= reg_wdata_i[3:2];
    end
  end
  enable_take_a: assert property (
    ctl_wr |=> converter_enable_o == $past(reg_wdata_i[7])) else $error("enable lost");
  prio_take_a: assert property (
    reg_wr_i && reg_addr_i == 8'hF7 |=> eoc_priority_o == $past(reg_wdata_i[4]))
    else $error("priority lost");
  off_quiet_a: assert property (
    !converter_enable_o |-> !conv_clk_en_o && !sample_o) else $error("runs while off");
  idle_quiet_a: assert property (
    sample_o |-> !conv_clk_en_o) else $error("clock while idle");
  done_at_end_a: assert property (
    $rose(eoc_irq_o) && !$past(reg_wr_i) |-> $rose(sample_o)) else $error("done without finish");
  sw_start_a: assert property (
    ctl_wr && reg_wdata_i == 8'h90 && sample_o && src_seen_q == 2'b00 |=> !sample_o)
    else $error("no start");
  done_clear_a: assert property (
    ctl_wr && !reg_wdata_i[5] && sample_o |=> !eoc_irq_o) else $error("done not cleared");
  irq_mask_a: assert property (
    reg_wr_i && reg_addr_i == 8'hE7 && !reg_wdata_i[4] |=> !eoc_irq_o) else $error("unmasked");
  rdata_hold_a: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
  // main scenarios reached
  done_c: cover property ($rose(eoc_irq_o));
  start_c: cover property ($fell(sample_o));
  clock_c: cover property (conv_clk_en_o);
endmodule // conv_start_checker
bind conv_start_ctrl conv_start_checker u_chk (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .conv_clk_en_o(conv_clk_en_o),
  .sample_o(sample_o),
  .converter_enable_o(converter_enable_o),
  .eoc_irq_o(eoc_irq_o),
  .eoc_priority_o(eoc_priority_o)
);
`default_nettype wire

// *** test/conv_far_side.sv ***
// model of the timers, the start pin and the analog core
// assumes the bench calls fire between clock edges
`timescale 1ns/1ps
`default_nettype none
module conv_far_side (
  // clock
  input wire logic mclk_i,
  // overflows t2 low, t2 high, t3 low, t3 high; modes; pin; result
  output logic [3:0] ovf_o,
  output logic [1:0] split_o,
  output logic pin_o,
  output logic [9:0] result_o
);
  // timer 3 in 8-bit mode, timer 2 in 16-bit mode
  initial begin
    ovf_o = 4'h0;
    split_o = 2'b10;
    pin_o = 1'b0;
    result_o = 10'h000;
  end
  // index 4 raises the pin, others give a one-cycle overflow
  task automatic fire(input int i, input logic [9:0] r);
    result_o = r;
    pin_o = 1'b0; // pin held low long enough for the synchroniser
    repeat (4) @(posedge mclk_i);
    #1;
    if (i > 3) pin_o = 1'b1;
    else ovf_o[i] = 1'b1;
    @(posedge mclk_i);
    #1;
    ovf_o = 4'h0;
  endtask
endmodule // conv_far_side
`default_nettype wire

// *** test/adc_conversion_start_control_tb_top.sv ***
// top testbench for the converter start control block
// assumes the far-side model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_start_control_tb_top;
  localparam int CC = 4;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  wire [7:0] reg_rdata_o;
  wire [3:0] ovf;
  wire [1:0] split;
  wire pin;
  wire [9:0] res;
  wire conv_clk_en_o, sample_o, converter_enable_o, eoc_irq_o, eoc_priority_o;
  int fail_count = 0;
  int checks = 0;
  int tick_count = 0;
  int wrong_idx[4] = '{4, 3, 2, 0};
  int right_idx[4] = '{0, 2, 4, 1};
  conv_start_ctrl #(.CONV_CLOCKS(CC), .MIN_SAMPLE_CYCLES(2)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .timer2_low_ovf_i(ovf[0]), .timer2_high_ovf_i(ovf[1]), .timer2_split_i(split[0]),
    .timer3_low_ovf_i(ovf[2]), .timer3_high_ovf_i(ovf[3]), .timer3_split_i(split[1]),
    .external_convert_start_i(pin), .sar_result_i(res), .conv_clk_en_o(conv_clk_en_o),
    .sample_o(sample_o), .converter_enable_o(converter_enable_o), .eoc_irq_o(eoc_irq_o),
    .eoc_priority_o(eoc_priority_o));
  conv_far_side u_far (.mclk_i(mclk_i), .ovf_o(ovf), .split_o(split), .pin_o(pin), .result_o(res));
  // 250 MHz clock
  initial forever #2 mclk_i = ~mclk_i;
  // conversion clock pulses, counted at the edges where the design acts on them
  always @(posedge mclk_i) begin
    if (conv_clk_en_o === 1'b1) begin
      tick_count++;
    end
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick;
    reg_wr_i = 1'b0;
  endtask
  // read data is registered, so it is looked at one edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick;
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, e);
  endtask
  // one conversion from source s; wrong triggers first must not start it
  task automatic conv(input logic [1:0] s, input logic [4:0] dv, input logic ie,
                      input logic [9:0] r);
    int n;
    wr(8'hE7, {3'h0, ie, 4'h8});
    rd(8'hE7, {3'h0, ie, 4'h8});
    wr(8'hBC, {dv, 3'h0});
    wr(8'hBA, {4'h8, s, 2'h0});
    chk(converter_enable_o, 1'b1);
    u_far.fire(wrong_idx[s], r);
    repeat (4) tick;
    chk(sample_o, 1'b1);
    tick_count = 0;
    if (s == 2'd0) wr(8'hBA, 8'h90);
    else u_far.fire(right_idx[s], r);
    for (n = 0; n < 8 && sample_o === 1'b1; n++) tick;
    n = 0;
    if (s == 2'd0) begin
      wr(8'hBA, 8'h90); // restart while busy is dropped
      n = 2;
    end
    for (; n < 300 && sample_o !== 1'b1; n++) begin
      tick;
    end
    if (n >= 300) begin
      fail_count++;
      give_verdict;
    end
    chk(10'(n), 10'(CC * (dv + 1)));
    chk(10'(tick_count), 10'(CC));
    chk(eoc_irq_o, ie);
    rd(8'hBA, {4'hA, s, 2'h0});
    rd(8'hBF, {6'h00, r[9:8]});
    rd(8'hBE, r[7:0]);
    wr(8'hBA, {4'h8, s, 2'h0});
    chk(eoc_irq_o, 1'b0);
    rd(8'hBA, {4'h8, s, 2'h0});
    $display("conversion test source %0d done", s);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    rd(8'hBC, 8'hF8);
    rd(8'hBA, 8'h00);
    rd(8'hE7, 8'h00);
    rd(8'hF7, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hF7, 8'hFF);
    rd(8'hF7, 8'hFF);
    chk(eoc_priority_o, 1'b1);
    wr(8'hF7, 8'h00);
    chk(eoc_priority_o, 1'b0);
    wr(8'hBA, 8'h10);
    rd(8'hBA, 8'h00);
    chk(sample_o, 1'b0);
    chk(converter_enable_o, 1'b0);
    $display("register test done");
    conv(2'd0, 5'd0, 1'b1, 10'h2A5);
    conv(2'd1, 5'd1, 1'b1, 10'h15A);
    conv(2'd2, 5'd2, 1'b1, 10'h3FF);
    conv(2'd3, 5'd31, 1'b1, 10'h001);
    conv(2'd0, 5'd0, 1'b0, 10'h300);
    give_verdict;
  end
endmodule // adc_conversion_start_control_tb_top
`default_nettype wire
